// ===== logic/bws_decode.sv
`timescale 1ns/1ps
// claims requests against both windows and translates the address
module bws_decode (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // request
  input  wire logic        req_valid,
  input  wire logic [63:0] req_addr,
  input  wire logic        req_io,
  // window zero
  input  wire logic [63:4] w0_base,
  input  wire logic [63:4] w0_mask,
  input  wire logic        w0_io,
  input  wire logic        w0_is64,
  input  wire logic [63:4] w0_xlat,
  // window one
  input  wire logic [63:4] w1_base,
  input  wire logic [63:4] w1_mask,
  input  wire logic        w1_io,
  input  wire logic        w1_active,
  input  wire logic [63:4] w1_xlat,
  // result
  output logic             hit0_r,
  output logic             hit1_r,
  output logic [63:0]      xlat_addr_r
);

  logic hit0_nxt;
  logic hit1_nxt;

  function automatic logic match(input logic [63:0] addr, input logic [63:4] base,
                                 input logic [63:4] m, input logic wide);
    // an all-zero mask means the window is off and claims nothing
    match = (|m) && ((addr[63:4] & m) == (base & m)) && (wide || (addr[63:32] == 32'h0));
  endfunction

  function automatic logic [63:0] xlate(input logic [63:0] addr, input logic [63:4] tb,
                                        input logic [63:4] m);
    xlate = {(tb & m) | (addr[63:4] & ~m), addr[3:0]};
  endfunction

  always_comb begin
    hit0_nxt = req_valid && (req_io == w0_io) && match(req_addr, w0_base, w0_mask, w0_is64);
    hit1_nxt = req_valid && w1_active && (req_io == w1_io)
            && match(req_addr, w1_base, w1_mask, 1'b0);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit0_r      <= 1'b0;
      hit1_r      <= 1'b0;
      xlat_addr_r <= 64'h0;
    end else begin
      hit0_r <= hit0_nxt;
      hit1_r <= hit1_nxt && !hit0_nxt;
      if (hit0_nxt) begin
        xlat_addr_r <= xlate(req_addr, w0_xlat, w0_mask);
      end else if (hit1_nxt) begin
        xlat_addr_r <= xlate(req_addr, w1_xlat, w1_mask);
      end else begin
        xlat_addr_r <= req_addr;
      end
    end
  end

endmodule // bws_decode

// ===== logic/bws_mask.sv
`timescale 1ns/1ps
// writable-bit mask for one window's base-address field, bus bits 63:4
module bws_mask (
  // setup fields
  input  wire logic [5:0]  size,
  input  wire logic        enable,
  input  wire logic        is64,
  // result
  output logic      [63:4] mask
);

  logic [5:0] eff_size;
  logic       size_ok;

  always_comb begin
    // outside 64-bit mode, sizes above 32 only reach bit 32
    if (!is64 && (size > bws_pkg::SIZE_LIM_32)) begin
      eff_size = bws_pkg::SIZE_LIM_32;
    end else begin
      eff_size = size;
    end
    size_ok = enable && ((size == bws_pkg::SIZE_ALL) ||
                         (size >= bws_pkg::SIZE_MIN_OK));
    for (int a = bws_pkg::BASE_LSB; a < 64; a++) begin
      mask[a] = size_ok
             && ((size == bws_pkg::SIZE_ALL) || (7'(a) >= {1'b0, eff_size}))
             && (is64 || (a < 32));
    end
  end

endmodule // bws_mask

// ===== logic/bws_pkg.sv
package bws_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_WIN0_BASE     = 8'h10;
  localparam logic [7:0] OFS_WIN1_BASE     = 8'h14;
  localparam logic [7:0] OFS_WIN0_SETUP    = 8'h7c;
  localparam logic [7:0] OFS_WIN0_XLAT_LO  = 8'h80;
  localparam logic [7:0] OFS_WIN1_SETUP    = 8'h84;
  localparam logic [7:0] OFS_WIN1_XLAT     = 8'h88;

  // setup register field positions
  localparam int SETUP_SPACE_BIT = 0;
  localparam int SETUP_TYPE_LSB  = 1;
  localparam int SETUP_PREF_BIT  = 3;
  localparam int SETUP_SIZE_LSB  = 4;
  localparam int SETUP_SIZE_MSB  = 9;
  localparam int SETUP_EN_BIT    = 31;

  // base and translated-base fields start at bus address bit four
  localparam int BASE_LSB = 4;

  // size field limits
  localparam logic [5:0] SIZE_RESET   = 6'h01;
  localparam logic [5:0] SIZE_ALL     = 6'h00;
  localparam logic [5:0] SIZE_MIN_OK  = 6'h04;
  localparam logic [5:0] SIZE_LIM_32  = 6'h20;

  // space select and addressing type codes
  localparam logic       SPACE_MEM    = 1'b0;
  localparam logic       SPACE_IO     = 1'b1;
  localparam logic [1:0] TYPE_ADDR32  = 2'h0;
  localparam logic [1:0] TYPE_ADDR64  = 2'h2;

  localparam logic       EN_RESET     = 1'b0;
  localparam logic [31:0] XLAT_RESET  = 32'h0000_0000;

  typedef enum logic [1:0] {
    BWS_BUS_IDLE = 2'b01,
    BWS_BUS_ACK  = 2'b10
  } bws_bus_t;

endpackage

// ===== logic/bws_window.sv
`timescale 1ns/1ps
// Overview of operation
// - six-bit size field, window size in address bits, resets to one, zero acts as four, every base bit writable
// - base field bit zero corresponds to bus address bit four
// - size zero makes every base-address bit writable
// - nonzero size: only base bits at or above size are writable
// - base bits from four up to below size read zero, ignore writes
// - size one to three forces base field read-only zero, window off
// - I/O or 32-bit memory ignores size bits beyond 32
// - setup bit 31 enables window; disabled window reads zero; resets zero
// - setup and translated-base fields survive hot reset
// - window zero 64-bit memory: upper translated register is full upper 32 bits
// - otherwise upper translated register bits 31:4 translate window one, 3:0 zero
// - window zero 64-bit memory: window-one setup reads zero, read-only
// - space select 0 memory, 1 I/O; type 0 32-bit, 2 64-bit
module bws_window #(
  parameter int ADDR_W = 8
) (
  // clock and resets
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hot_rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // address decode
  input  wire logic        req_valid,
  input  wire logic [63:0] req_addr,
  input  wire logic        req_io,
  output logic             hit0,
  output logic             hit1,
  output logic      [63:0] xlat_addr
);

  if (ADDR_W < 8) begin : g_chk
    $error("bws_window: ADDR_W must be at least 8");
  end

  bws_pkg::bws_bus_t bus_r;

  // setup fields, window zero
  logic       w0_space_r;
  logic [1:0] w0_type_r;
  logic       w0_pref_r;
  logic [5:0] w0_size_r;
  logic       w0_en_r;
  // setup fields, window one
  logic       w1_space_r;
  logic [1:0] w1_type_r;
  logic       w1_pref_r;
  logic [5:0] w1_size_r;
  logic       w1_en_r;
  // translated bases and window bases
  logic [31:4] xlat_lo_r;
  logic [31:0] xlat_hi_r;
  logic [63:4] base0_r;
  logic [31:4] base1_r;

  logic [63:4] mask0;
  logic [63:4] mask1;
  logic        w0_is64;
  logic        req_take;
  logic        wr_take;
  logic [31:0] lane;
  logic [7:0]  byte_adr;
  logic [31:0] rd_nxt;
  logic        hot_meta_r;
  logic        hot_sync_r;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // merge over the whole dword, keep bits 31:4 of the result
  function automatic logic [31:4] upper_merge(input logic [31:4] old, input logic [31:0] nw,
                                              input logic [31:0] m);
    logic [31:0] w;
    w = merge({old, 4'h0}, nw, m);
    upper_merge = w[31:4];
  endfunction

  // size field straddles byte lanes zero and one, each lane decides its own bits
  function automatic logic [5:0] size_merge(input logic [5:0] old, input logic [31:0] nw,
                                            input logic [31:0] m);
    logic [31:0] w;
    w = merge({22'h0, old, 4'h0}, nw, m);
    size_merge = w[bws_pkg::SETUP_SIZE_MSB:bws_pkg::SETUP_SIZE_LSB];
  endfunction

  // low dword of a window base as software sees it
  function automatic logic [31:0] bar_word(input logic [31:4] b, input logic [31:4] m,
                                           input logic en, input logic sp,
                                           input logic [1:0] ty, input logic pf);
    if (!en) begin
      bar_word = 32'h0;
    end else begin
      bar_word = {b & m, pf, ty, sp};
    end
  endfunction

  function automatic logic [31:0] setup_word(input logic sp, input logic [1:0] ty,
                                             input logic pf, input logic [5:0] sz,
                                             input logic en);
    setup_word = 32'h0;
    setup_word[bws_pkg::SETUP_SPACE_BIT] = sp;
    setup_word[bws_pkg::SETUP_TYPE_LSB +: 2] = ty;
    setup_word[bws_pkg::SETUP_PREF_BIT] = pf;
    setup_word[bws_pkg::SETUP_SIZE_MSB:bws_pkg::SETUP_SIZE_LSB] = sz;
    setup_word[bws_pkg::SETUP_EN_BIT] = en;
  endfunction

  assign w0_is64  = (w0_space_r == bws_pkg::SPACE_MEM) && (w0_type_r == bws_pkg::TYPE_ADDR64);
  assign byte_adr = {wb_adr_i[7:2], 2'b00};
  assign req_take = wb_cyc_i && wb_stb_i && (bus_r == bws_pkg::BWS_BUS_IDLE);
  // reads are latched when taken, writes land on the edge that sees ack
  assign wr_take  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign lane     = lane_mask(wb_sel_i);

  bws_mask u_mask0 (
    .size   (w0_size_r),
    .enable (w0_en_r),
    .is64   (w0_is64),
    .mask   (mask0)
  );

  // window one is never 64-bit and is off while it is window zero's upper half
  bws_mask u_mask1 (
    .size   (w1_size_r),
    .enable (w1_en_r && !w0_is64),
    .is64   (1'b0),
    .mask   (mask1)
  );

  // bus handshake: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_r    <= bws_pkg::BWS_BUS_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      case (bus_r)
        bws_pkg::BWS_BUS_IDLE: begin
          wb_ack_o <= req_take;
          if (req_take) begin
            bus_r <= bws_pkg::BWS_BUS_ACK;
          end
        end
        bws_pkg::BWS_BUS_ACK: begin
          wb_ack_o <= 1'b0;
          bus_r    <= bws_pkg::BWS_BUS_IDLE;
        end
        default: begin
          wb_ack_o <= 1'b0;
          bus_r    <= bws_pkg::BWS_BUS_IDLE;
        end
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0;
    case (byte_adr)
      bws_pkg::OFS_WIN0_BASE: begin
        rd_nxt = bar_word(base0_r[31:4], mask0[31:4], w0_en_r, w0_space_r,
                          w0_type_r, w0_pref_r);
      end
      bws_pkg::OFS_WIN1_BASE: begin
        if (w0_is64) begin
          rd_nxt = w0_en_r ? (base0_r[63:32] & mask0[63:32]) : 32'h0;
        end else begin
          rd_nxt = bar_word(base1_r, mask1[31:4], w1_en_r, w1_space_r,
                            w1_type_r, w1_pref_r);
        end
      end
      bws_pkg::OFS_WIN0_SETUP: begin
        rd_nxt = setup_word(w0_space_r, w0_type_r, w0_pref_r, w0_size_r, w0_en_r);
      end
      bws_pkg::OFS_WIN0_XLAT_LO: begin
        rd_nxt = {xlat_lo_r, 4'h0};
      end
      bws_pkg::OFS_WIN1_SETUP: begin
        if (!w0_is64) begin
          rd_nxt = setup_word(w1_space_r, w1_type_r, w1_pref_r, w1_size_r, w1_en_r);
        end
      end
      bws_pkg::OFS_WIN1_XLAT: begin
        if (w0_is64) begin
          rd_nxt = xlat_hi_r;
        end else begin
          rd_nxt = {xlat_hi_r[31:4], 4'h0};
        end
      end
      default: begin
        rd_nxt = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0;
    end else if (req_take && !wb_we_i) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // setup registers: only the power-on reset clears them, hot reset does not
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      w0_space_r <= bws_pkg::SPACE_MEM;
      w0_type_r  <= bws_pkg::TYPE_ADDR32;
      w0_pref_r  <= 1'b0;
      w0_size_r  <= bws_pkg::SIZE_RESET;
      w0_en_r    <= bws_pkg::EN_RESET;
    end else if (wr_take && (byte_adr == bws_pkg::OFS_WIN0_SETUP)) begin
      if (wb_sel_i[0]) begin
        w0_space_r <= wb_dat_i[bws_pkg::SETUP_SPACE_BIT];
        w0_pref_r  <= wb_dat_i[bws_pkg::SETUP_PREF_BIT];
        // I/O space keeps type zero; only 32-bit and 64-bit codes are taken
        if (wb_dat_i[bws_pkg::SETUP_SPACE_BIT] == bws_pkg::SPACE_IO ||
            (wb_dat_i[bws_pkg::SETUP_TYPE_LSB +: 2] != bws_pkg::TYPE_ADDR64)) begin
          w0_type_r <= bws_pkg::TYPE_ADDR32;
        end else begin
          w0_type_r <= bws_pkg::TYPE_ADDR64;
        end
      end
      w0_size_r <= size_merge(w0_size_r, wb_dat_i, lane);
      if (wb_sel_i[3]) begin
        w0_en_r <= wb_dat_i[bws_pkg::SETUP_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      w1_space_r <= bws_pkg::SPACE_MEM;
      w1_type_r  <= bws_pkg::TYPE_ADDR32;
      w1_pref_r  <= 1'b0;
      w1_size_r  <= bws_pkg::SIZE_RESET;
      w1_en_r    <= bws_pkg::EN_RESET;
    end else if (wr_take && (byte_adr == bws_pkg::OFS_WIN1_SETUP) && !w0_is64) begin
      if (wb_sel_i[0]) begin
        w1_space_r <= wb_dat_i[bws_pkg::SETUP_SPACE_BIT];
        w1_pref_r  <= wb_dat_i[bws_pkg::SETUP_PREF_BIT];
        // window one has no 64-bit code
        w1_type_r  <= bws_pkg::TYPE_ADDR32;
      end
      w1_size_r <= size_merge(w1_size_r, wb_dat_i, lane);
      if (wb_sel_i[3]) begin
        w1_en_r <= wb_dat_i[bws_pkg::SETUP_EN_BIT];
      end
    end
  end

  // translated bases survive hot reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xlat_lo_r <= bws_pkg::XLAT_RESET[31:4];
      xlat_hi_r <= bws_pkg::XLAT_RESET;
    end else if (wr_take) begin
      if (byte_adr == bws_pkg::OFS_WIN0_XLAT_LO) begin
        xlat_lo_r <= upper_merge(xlat_lo_r, wb_dat_i, lane);
      end
      if (byte_adr == bws_pkg::OFS_WIN1_XLAT) begin
        // low nibble is kept so it reappears in 64-bit mode; read masks it otherwise
        xlat_hi_r <= merge(xlat_hi_r, wb_dat_i, lane);
      end
    end
  end

  // hot reset may come from a pin: two flops before the bases see it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hot_meta_r <= 1'b0;
      hot_sync_r <= 1'b0;
    end else begin
      hot_meta_r <= hot_rst;
      hot_sync_r <= hot_meta_r;
    end
  end

  // window bases: only writable bits change, hot reset clears them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base0_r <= 60'h0;
      base1_r <= 28'h0;
    end else if (hot_sync_r) begin
      base0_r <= 60'h0;
      base1_r <= 28'h0;
    end else if (wr_take) begin
      if (byte_adr == bws_pkg::OFS_WIN0_BASE) begin
        base0_r[31:4] <= upper_merge(base0_r[31:4], wb_dat_i,
                                     lane & {mask0[31:4], 4'h0});
      end
      if (byte_adr == bws_pkg::OFS_WIN1_BASE) begin
        if (w0_is64) begin
          base0_r[63:32] <= merge(base0_r[63:32], wb_dat_i, lane & mask0[63:32]);
        end else begin
          base1_r <= upper_merge(base1_r, wb_dat_i, lane & {mask1[31:4], 4'h0});
        end
      end
    end
  end

  // bws_mask turns a window off for sizes one to three and clamps sizes above 32 outside 64-bit mode
  bws_decode u_decode (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .req_valid   (req_valid),
    .req_addr    (req_addr),
    .req_io      (req_io),
    .w0_base     (base0_r),
    .w0_mask     (mask0),
    .w0_io       (w0_space_r),
    .w0_is64     (w0_is64),
    .w0_xlat     (w0_is64 ? {xlat_hi_r, xlat_lo_r} : {32'h0, xlat_lo_r}),
    .w1_base     ({32'h0, base1_r}),
    .w1_mask     (mask1),
    .w1_io       (w1_space_r),
    .w1_active   (!w0_is64),
    .w1_xlat     ({32'h0, xlat_hi_r[31:4]}),
    .hit0_r      (hit0),
    .hit1_r      (hit1),
    .xlat_addr_r (xlat_addr)
  );

endmodule // bws_window

// ===== tb/bws_window_asserts.sv
`timescale 1ns/1ps
module bws_window_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // decode
  input wire logic        req_valid,
  input wire logic [63:0] req_addr,
  input wire logic        hit0,
  input wire logic        hit1,
  input wire logic [63:0] xlat_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
  chk_ack_timely: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_caused: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // read data must not move on writes or idle cycles
  chk_rdata_held: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data changed outside a read");
  chk_hit_exclusive: assert property (!(hit0 && hit1))
    else $error("both windows claimed");
  chk_hit_caused: assert property ((hit0 || hit1) |-> $past(req_valid))
    else $error("hit without request");
  chk_miss_passthru: assert property (
    $past(req_valid) && !hit0 && !hit1 |-> xlat_addr == $past(req_addr))
    else $error("missed request address altered");
  chk_nibble_kept: assert property (
    (hit0 || hit1) |-> xlat_addr[3:0] == $past(req_addr[3:0]))
    else $error("low nibble altered by translation");
endmodule // bws_window_asserts

bind bws_window bws_window_asserts u_chk (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .req_valid(req_valid), .req_addr(req_addr), .hit0(hit0), .hit1(hit1),
  .xlat_addr(xlat_addr)
);

// ===== tb/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        clk, sys_rst, hot_rst, cyc, stb, we, rv, rio, h0, h1, ack, pend;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, r, rexp;
  logic [63:0] ra, xa;
  logic [65:0] dexp;
  int          sizes[8];
  logic [15:0] lf;
  logic [31:0] rdq[$];
  logic [65:0] dcq[$];
  int          errors, compares;

  bws_window i_dut (
    .clk(clk), .sys_rst(sys_rst), .hot_rst(hot_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .req_valid(rv),
    .req_addr(ra), .req_io(rio), .hit0(h0), .hit1(h1), .xlat_addr(xa)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic results();
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one classic cycle; ack sampled before this edge's updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic req(input logic [63:0] a, input logic io, input logic [65:0] e);
    @(posedge clk);
    rv <= 1'b1; ra <= a; rio <= io;
    dcq.push_back(e);
    @(posedge clk);
    rv <= 1'b0; ra <= ~a;
  endtask

  // outputs settle after the edge, so results are taken mid-cycle
  always @(posedge clk) pend <= rv;
  always @(negedge clk) begin
    if (ack && !we && rdq.size() > 0) begin
      rexp = rdq.pop_front();
      `CHK(rdat, rexp)
    end
    if (pend && dcq.size() > 0) begin
      dexp = dcq.pop_front();
      `CHK({h0, h1, xa}, dexp)
    end
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #25000;
    errors++;
    results();
  end

  initial begin
    logic [31:0] m;
    errors = 0; compares = 0; sys_rst = 1'b1; hot_rst = 1'b0; cyc = 1'b0;
    stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hf; wdat = 32'h0; rv = 1'b0;
    ra = 64'h0; rio = 1'b0; pend = 1'b0; lf = 16'hc944;
    sizes = '{0, 1, 3, 4, 7, 12, 20, 31};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h7c, 32'h0000_0010);
    rd(8'h88, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, 8'h7c, 32'hffff_ffff);
    rd(8'h7c, 32'h8000_03f9);
    bus(1'b1, 8'h10, 32'hffff_fff0);
    rd(8'h10, 32'h0000_0009);
    foreach (sizes[i]) begin
      int sz;
      sz = sizes[i];
      m = (sz == 0) ? 32'hffff_fff0 : (sz < 4) ? 32'h0 : ~((32'h1 << sz) - 32'h1);
      bus(1'b1, 8'h7c, 32'h8000_0000 | (sz << 4));
      bus(1'b1, 8'h10, 32'hffff_fff0);
      rd(8'h10, m & 32'hffff_fff0);
    end
    bus(1'b1, 8'h7c, 32'h0000_0080);
    rd(8'h10, 32'h0);
    lf = lfsr(lf); r[31:16] = lf; lf = lfsr(lf); r[15:0] = lf;
    bus(1'b1, 8'h7c, 32'h8000_00c4);
    bus(1'b1, 8'h84, 32'h8000_0070);
    rd(8'h84, 32'h0);
    bus(1'b1, 8'h88, r);
    rd(8'h88, r);
    bus(1'b1, 8'h10, 32'h0000_5000);
    bus(1'b1, 8'h14, 32'h0000_0001);
    bus(1'b1, 8'h80, 32'h000a_0000);
    rd(8'h10, 32'h0000_5004);
    rd(8'h14, 32'h0000_0001);
    req({32'h1, 32'h0000_5abc}, 1'b0, {2'b10, r, 32'h000a_0abc});
    req({32'h1, 32'h0000_5abc}, 1'b1, {2'b00, 32'h1, 32'h0000_5abc});
    bus(1'b1, 8'h7c, 32'h0000_00c4);
    req({32'h1, 32'h0000_5abc}, 1'b0, {2'b00, 32'h1, 32'h0000_5abc});
    rd(8'h88, r);
    bus(1'b1, 8'h7c, 32'h0000_0000);
    rd(8'h88, r & 32'hffff_fff0);
    bus(1'b1, 8'h84, 32'h8000_0080);
    bus(1'b1, 8'h14, 32'h0000_33f0);
    ra <= {48'h0, 8'h33, lf[7:0]};
    req({48'h0, 16'h3345}, 1'b0, {2'b01, 32'h0, r[31:8], 8'h45});
    @(posedge clk);
    hot_rst <= 1'b1;
    @(posedge clk);
    hot_rst <= 1'b0;
    rd(8'h84, 32'h8000_0080);
    rd(8'h88, r & 32'hffff_fff0);
    rd(8'h14, 32'h0);
    repeat (4) @(posedge clk);
    if (rdq.size() != 0 || dcq.size() != 0) errors++;
    results();
  end
endmodule // testbench
